// ==== design/bridge_pwm_consts.vh ====
// Purpose: Constants for the bridge PWM output steering block
// Assumes: 10 MHz clock, one instruction cycle per four clocks
// Notes:   Register offsets are word-aligned byte addresses
`ifndef BRIDGE_PWM_CONSTS_VH
`define BRIDGE_PWM_CONSTS_VH

// Register byte offsets
`define OFS_PERIOD      5'h00
`define OFS_DUTY        5'h04
`define OFS_CONTROL     5'h08
`define OFS_DEADBAND    5'h0C
`define OFS_STATUS      5'h10
`define OFS_DIRECTION   5'h14

// Control field positions
`define CTL_POL_AC      0
`define CTL_POL_BD      1
`define CTL_CFG_LO      2
`define CTL_CFG_HI      3
`define CTL_ENABLE      4

// Output configuration encodings
`define CFG_SINGLE      2'h0
`define CFG_FULL_FWD    2'h1
`define CFG_HALF        2'h2
`define CFG_FULL_REV    2'h3

// Reset values
`define PERIOD_RST      8'hFF
`define DUTY_RST        10'h000
`define DIR_RST         4'hF

// Clocks per instruction cycle
`define CLK_PER_INSTR   4

`endif

// ==== design/bridge_pwm_steering.v ====
// Purpose: PWM generator with half-bridge and full-bridge output steering
// Assumes: Avalon-MM slave with waitrequest, synchronous active-low reset
// Notes:   Direction change sequencing and shutdown logic are not present
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`include "bridge_pwm_consts.vh"
`default_nettype none

// Function
// [RQ1] Half-bridge: PWM on A, complement on B
// [RQ2] Delay each activating edge by dead-band count
// [RQ3] Dead-band above duty keeps output inactive
// [RQ4] Forward: A active, D modulated, B C inactive
// [RQ5] Reverse: C active, B modulated, A D inactive
// [RQ6] Direction bits clear before pin drives PWM
// [RQ7] Mode field selects single, half, forward, reverse
// [RQ8] Separate polarity for pairs A/C and B/D
// [RQ9] Period match: clear timer, set output, latch duty
// [RQ10] Clear modulation when time base equals duty
// [RQ11] Unused outputs released to alternate function
module bridge_pwm_steering (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_b,
  // Avalon-MM slave
  input  wire [4:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  // Steered outputs
  output reg         steer_out_a,
  output reg         steer_out_b,
  output reg         steer_out_c,
  output reg         steer_out_d,
  // Output enables, high while block drives pin
  output reg         steer_oe_a,
  output reg         steer_oe_b,
  output reg         steer_oe_c,
  output reg         steer_oe_d
);

  localparam CFG_W = 2;

  // Registers
  reg  [7:0]       period_value;
  reg  [9:0]       duty_buffer;
  reg  [9:0]       duty_latched;
  reg  [4:0]       control_reg;
  reg  [6:0]       deadband_count;
  reg  [3:0]       pin_direction_bits;
  reg              ack_reg;

  // Time base
  reg  [7:0]       period_timer;
  reg  [1:0]       prescale_bits;
  reg              modulated;
  reg              running;
  wire [9:0]       time_base;
  wire [9:0]       time_base_inc;
  wire             instr_tick;
  wire             period_end;
  wire [CFG_W-1:0] output_config_field;
  wire             pol_ac;
  wire             pol_bd;

  // Dead-band paths
  wire             half_a_raw;
  wire             half_b_raw;
  wire             half_a_del;
  wire             half_b_del;

  reg  [3:0]       level_next;
  reg  [3:0]       use_next;

  // Polarity adjust: active-low inverts
  function apply_pol;
    input level;
    input low_active;
    begin
      apply_pol = low_active ? ~level : level;
    end
  endfunction

  assign output_config_field = control_reg[`CTL_CFG_HI:`CTL_CFG_LO];
  assign pol_ac              = control_reg[`CTL_POL_AC];
  assign pol_bd              = control_reg[`CTL_POL_BD];
  assign time_base           = {period_timer, prescale_bits};
  // Clear one clock early so the pulse spans exactly duty clocks
  assign time_base_inc       = time_base + 10'h001;
  assign instr_tick          = (prescale_bits == 2'h3);
  assign period_end          = instr_tick && (period_timer == period_value);

  // Bus: one wait cycle per access
  assign waitrequest = (read || write) && !ack_reg;

  always @(posedge clock) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read || write) && !ack_reg;
    end
  end

  // Register writes
  always @(posedge clock) begin
    if (!rst_b) begin
      period_value       <= `PERIOD_RST;
      duty_buffer        <= `DUTY_RST;
      control_reg        <= 5'h00;
      deadband_count     <= 7'h00;
      pin_direction_bits <= `DIR_RST;
    end else if (write && ack_reg) begin
      if (address == `OFS_PERIOD) begin
        period_value <= writedata[7:0];
      end else if (address == `OFS_DUTY) begin
        duty_buffer <= writedata[9:0];
      end else if (address == `OFS_CONTROL) begin
        control_reg <= writedata[4:0];
      end else if (address == `OFS_DEADBAND) begin
        deadband_count <= writedata[6:0];
      end else if (address == `OFS_DIRECTION) begin
        pin_direction_bits <= writedata[3:0];
      end
    end
  end

  // Register reads
  always @(posedge clock) begin
    if (!rst_b) begin
      readdata <= 32'h00000000;
    end else if (read && !ack_reg) begin
      if (address == `OFS_PERIOD) begin
        readdata <= {24'h000000, period_value};
      end else if (address == `OFS_DUTY) begin
        readdata <= {22'h000000, duty_buffer};
      end else if (address == `OFS_CONTROL) begin
        readdata <= {27'h0000000, control_reg};
      end else if (address == `OFS_DEADBAND) begin
        readdata <= {25'h0000000, deadband_count};
      end else if (address == `OFS_STATUS) begin
        readdata <= {12'h000, duty_latched, period_timer, running, modulated};
      end else if (address == `OFS_DIRECTION) begin
        readdata <= {28'h0000000, pin_direction_bits};
      end else begin
        readdata <= 32'h00000000;
      end
    end
  end

  // Period timer and modulation
  always @(posedge clock) begin
    if (!rst_b || !control_reg[`CTL_ENABLE]) begin
      period_timer  <= 8'h00;
      prescale_bits <= 2'h0;
      modulated     <= 1'b0;
      running       <= 1'b0;
      duty_latched  <= `DUTY_RST;
    end else begin
      prescale_bits <= prescale_bits + 2'h1;
      if (period_end) begin
        period_timer <= 8'h00; // [RQ9]
        duty_latched <= duty_buffer; // [RQ9]
        modulated    <= (duty_buffer != 10'h000); // [RQ9]
        running      <= 1'b1;
      end else begin
        if (instr_tick) begin
          period_timer <= period_timer + 8'h01;
        end
        if (time_base_inc == duty_latched) begin
          modulated <= 1'b0; // [RQ10]
        end
      end
    end
  end

  assign half_a_raw = running && modulated; // [RQ1]
  assign half_b_raw = running && !modulated; // [RQ1]

  deadband_delay u_delay_a (
    .clock       (clock),
    .rst_b       (rst_b),
    .delay_count (deadband_count),
    .raw_in      (half_a_raw),
    .delayed_out (half_a_del)
  );

  deadband_delay u_delay_b (
    .clock       (clock),
    .rst_b       (rst_b),
    .delay_count (deadband_count),
    .raw_in      (half_b_raw),
    .delayed_out (half_b_del)
  );

  // Steering: {d, c, b, a} active levels and usage
  always @* begin
    level_next = 4'h0;
    use_next   = 4'h0;
    case (output_config_field) // [RQ7]
      `CFG_SINGLE: begin
        level_next = {3'h0, running && modulated};
        use_next   = 4'h1;
      end
      `CFG_HALF: begin
        level_next = {2'h0, half_b_del, half_a_del}; // [RQ2]
        use_next   = 4'h3;
      end
      `CFG_FULL_FWD: begin
        level_next = {running && modulated, 2'h0, running}; // [RQ4]
        use_next   = 4'hF;
      end
      `CFG_FULL_REV: begin
        level_next = {1'b0, running, running && modulated, 1'b0}; // [RQ5]
        use_next   = 4'hF;
      end
      default: begin
        level_next = 4'h0;
        use_next   = 4'h0;
      end
    endcase
    if (!control_reg[`CTL_ENABLE]) begin
      use_next = 4'h0;
    end
  end

  // Pin drive with polarity and direction
  always @(posedge clock) begin
    if (!rst_b) begin
      steer_out_a <= 1'b0;
      steer_out_b <= 1'b0;
      steer_out_c <= 1'b0;
      steer_out_d <= 1'b0;
      steer_oe_a  <= 1'b0;
      steer_oe_b  <= 1'b0;
      steer_oe_c  <= 1'b0;
      steer_oe_d  <= 1'b0;
    end else begin
      steer_out_a <= apply_pol(level_next[0], pol_ac); // [RQ8]
      steer_out_b <= apply_pol(level_next[1], pol_bd); // [RQ8]
      steer_out_c <= apply_pol(level_next[2], pol_ac); // [RQ8]
      steer_out_d <= apply_pol(level_next[3], pol_bd); // [RQ8]
      steer_oe_a  <= use_next[0] && !pin_direction_bits[0]; // [RQ6] [RQ11]
      steer_oe_b  <= use_next[1] && !pin_direction_bits[1]; // [RQ6] [RQ11]
      steer_oe_c  <= use_next[2] && !pin_direction_bits[2]; // [RQ6] [RQ11]
      steer_oe_d  <= use_next[3] && !pin_direction_bits[3]; // [RQ6] [RQ11]
    end
  end

endmodule

`default_nettype wire

// ==== design/deadband_delay.v ====
// Purpose: Delay the rising edge of one output by a count of instruction cycles
// Assumes: four clocks per instruction cycle, counted from the rising edge
// Notes:   A pulse shorter than the delay never appears at the output
`default_nettype none

module deadband_delay (
  // Clock and reset
  input  wire       clock,
  input  wire       rst_b,
  // Timing
  input  wire [6:0] delay_count,
  // Signal
  input  wire       raw_in,
  output reg        delayed_out
);

  reg  [8:0] count_reg;
  wire [8:0] limit;

  // Delay in clocks, so a mid-cycle edge still waits whole instruction cycles
  assign limit = {delay_count, 2'h0};

  always @(posedge clock) begin
    if (!rst_b) begin
      count_reg   <= 9'h000;
      delayed_out <= 1'b0;
    end else if (!raw_in) begin
      count_reg   <= 9'h000;
      delayed_out <= 1'b0;
    end else if (count_reg >= limit) begin
      delayed_out <= 1'b1; // [RQ2]
    end else begin
      count_reg <= count_reg + 9'h001; // [RQ3]
    end
  end

endmodule

`default_nettype wire

// ==== dv/bridge_pwm_props_properties.sv ====
// Purpose: Port checks for the PWM steering block
// Assumes: Mode and direction are tracked from bus writes
// Notes:   Mode checks wait three cycles after any write
`include "bridge_pwm_consts.vh"
`default_nettype none
module bridge_pwm_props (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // Bus
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Pins
  input wire logic        steer_out_a,
  input wire logic        steer_out_b,
  input wire logic        steer_out_c,
  input wire logic        steer_out_d,
  input wire logic        steer_oe_a,
  input wire logic        steer_oe_b,
  input wire logic        steer_oe_c,
  input wire logic        steer_oe_d
);
  logic [4:0]      ctl_q;
  logic [3:0]      dir_q;
  logic [1:0]      age_q;
  wire logic       upd = write && !waitrequest;
  wire logic       ok  = age_q == 2'h3 && ctl_q[4];
  wire logic [1:0] cf  = ctl_q[3:2];
  wire logic [3:0] oe  = {steer_oe_d, steer_oe_c, steer_oe_b, steer_oe_a};
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctl_q <= 5'h00;
      dir_q <= 4'hF;
      age_q <= 2'h0;
    end else begin
      if (upd && address == `OFS_CONTROL) ctl_q <= writedata[4:0];
      if (upd && address == `OFS_DIRECTION) dir_q <= writedata[3:0];
      age_q <= upd ? 2'h0 : (age_q == 2'h3 ? age_q : age_q + 2'h1);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  fwd_levels_a: assert property (ok && cf == `CFG_FULL_FWD |->
    (!oe[0] || steer_out_a != ctl_q[0]) && (!oe[1] || steer_out_b == ctl_q[1])
    && (!oe[2] || steer_out_c == ctl_q[0])) else $error("forward levels wrong");
  rev_levels_a: assert property (ok && cf == `CFG_FULL_REV |->
    (!oe[0] || steer_out_a == ctl_q[0]) && (!oe[2] || steer_out_c != ctl_q[0])
    && (!oe[3] || steer_out_d == ctl_q[1])) else $error("reverse levels wrong");
  half_pair_a: assert property (ok && cf == `CFG_HALF && oe[1:0] == 2'h3 |->
    !(steer_out_a != ctl_q[0] && steer_out_b != ctl_q[1])) else $error("pair both active");
  half_free_a: assert property (ok && cf == `CFG_HALF |-> oe[3:2] == 2'h0)
    else $error("half mode drives C or D");
  single_free_a: assert property (ok && cf == `CFG_SINGLE |-> oe[3:1] == 3'h0)
    else $error("single mode drives B to D");
  dir_gate_a: assert property (age_q == 2'h3 |-> (oe & dir_q) == 4'h0)
    else $error("input pin driven");
  reset_clear_a: assert property (disable iff (1'b0) !rst_b |=> oe == 4'h0 && readdata == 32'h0)
    else $error("reset left outputs set");
  unmapped_a: assert property (read && !waitrequest && address > `OFS_DIRECTION |->
    readdata == 32'h0) else $error("unmapped read not zero");
endmodule
bind bridge_pwm_steering bridge_pwm_props u_bridge_pwm_props (.clock(clock), .rst_b(rst_b),
  .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .steer_out_a(steer_out_a), .steer_out_b(steer_out_b),
  .steer_out_c(steer_out_c), .steer_out_d(steer_out_d), .steer_oe_a(steer_oe_a),
  .steer_oe_b(steer_oe_b), .steer_oe_c(steer_oe_c), .steer_oe_d(steer_oe_d));
`default_nettype wire

// ==== dv/power_stage_model.sv ====
// Purpose: Switch driver stage on the four steered pins
// Assumes: External pull-downs on every gate node
// Notes:   A released pin reads low
`default_nettype none
module power_stage_model (
  // Block side
  input  wire logic [3:0] level,
  input  wire logic [3:0] enable,
  // Gate nodes
  output wire logic [3:0] gate
);
  timeunit 1ns;
  timeprecision 1ns;
  assign gate = level & enable;
endmodule
`default_nettype wire

// ==== dv/tb_bridge_pwm_steering.sv ====
// Purpose: Self-checking bench for the PWM steering block
// Assumes: Period 3 and duty 6 give a 16-clock cycle
// Notes:   Pin counts are high cycles over one period
`include "bridge_pwm_consts.vh"
`default_nettype none
module tb_bridge_pwm_steering;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [4:0] ctl; logic [3:0] dir, oe; logic [19:0] h;} row_t;
  logic        clock = 0, rst_b = 0, read = 0, write = 0;
  logic [4:0]  address = 5'h00;
  logic [31:0] writedata = 32'h0, rd;
  logic [4:0]  h [4];
  wire logic [31:0] readdata;
  wire logic        waitrequest;
  wire logic [3:0]  lv, oe, gate;
  int errors = 0, total_checks = 0;
  row_t rows [8] = '{'{5'h10, 4'h0, 4'h1, 20'h30000}, '{5'h18, 4'h0, 4'h3, 20'h32800},
    '{5'h14, 4'h0, 4'hF, 20'h80006}, '{5'h1C, 4'h0, 4'hF, 20'h01A00},
    '{5'h17, 4'h0, 4'hF, 20'h0420A}, '{5'h1D, 4'h0, 4'hF, 20'h81800},
    '{5'h1A, 4'h0, 4'h3, 20'h31800}, '{5'h14, 4'h9, 4'h6, 20'h00000}};
  bridge_pwm_steering u_bridge_pwm_steering (.clock(clock), .rst_b(rst_b), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .steer_out_a(lv[0]), .steer_out_b(lv[1]), .steer_out_c(lv[2]),
    .steer_out_d(lv[3]), .steer_oe_a(oe[0]), .steer_oe_b(oe[1]), .steer_oe_c(oe[2]),
    .steer_oe_d(oe[3]));
  power_stage_model u_power_stage_model (.level(lv), .enable(oe), .gate(gate));
  initial forever #50 clock = !clock;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    chk("readdata", e, rd);
  endtask
  task automatic meas;
    repeat (40) @(posedge clock);
    h = '{default: 5'h00};
    repeat (16) begin
      @(posedge clock);
      for (int i = 0; i < 4; i++) h[i] += 5'(gate[i]);
    end
  endtask
  task automatic close_out;
    $display("errors %0d total_checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #500000;
    errors++;
    close_out;
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rchk(`OFS_PERIOD, 32'hFF);
    rchk(`OFS_DUTY, 32'h0);
    rchk(`OFS_CONTROL, 32'h0);
    rchk(`OFS_DIRECTION, 32'hF);
    av(1'b1, 5'h18, 32'hFFFFFFFF);
    rchk(5'h18, 32'h0);
    av(1'b1, `OFS_PERIOD, 32'h3);
    av(1'b1, `OFS_DUTY, 32'h6);
    foreach (rows[i]) begin
      av(1'b1, `OFS_DIRECTION, {28'h0, rows[i].dir});
      av(1'b1, `OFS_CONTROL, {27'h0, rows[i].ctl});
      meas;
      chk("oe", {28'h0, rows[i].oe}, {28'h0, oe});
      chk("pins", {12'h0, rows[i].h}, {12'h0, h[0], h[1], h[2], h[3]});
    end
    av(1'b1, `OFS_DIRECTION, 32'h0);
    av(1'b1, `OFS_CONTROL, 32'h18);
    av(1'b1, `OFS_DEADBAND, 32'h7F);
    meas;
    chk("long dead", 32'h0, {22'h0, h[0], h[1]});
    av(1'b1, `OFS_DEADBAND, 32'h1);
    meas;
    chk("short dead", 32'h00000046, {22'h0, h[0], h[1]});
    av(1'b1, `OFS_CONTROL, 32'h14);
    av(1'b1, `OFS_DUTY, 32'h0);
    meas;
    chk("zero duty", 32'h0, {27'h0, h[3]});
    av(1'b1, `OFS_DUTY, 32'h3FF);
    meas;
    chk("full duty", 32'h10, {27'h0, h[3]});
    av(1'b0, `OFS_STATUS, 32'h0);
    chk("status", 32'h7FF, {21'h0, rd[19:10], rd[1]});
    rst_b <= 1'b0;
    repeat (10) @(posedge clock);
    chk("oe reset", 32'h0, {28'h0, oe});
    rst_b <= 1'b1;
    @(posedge clock);
    rchk(`OFS_CONTROL, 32'h0);
    close_out;
  end
endmodule
`default_nettype wire
